// >>> design/srt_sdram_cfg.svh
`ifndef SRT_SDRAM_CFG_SVH
`define SRT_SDRAM_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define SRT_OFS_CTRL 8'h00
`define SRT_OFS_STATUS 8'h04
`define SRT_OFS_BLK0 8'h08
`define SRT_OFS_BLK1 8'h0C
`define SRT_OFS_MASK0 8'h10
`define SRT_OFS_MASK1 8'h14

// ----------------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------------
`define SRT_CTRL_RST 16'h0000
`define SRT_BLK_RST 32'h00000000
`define SRT_MASK_RST 32'h00000000
`define SRT_CTRL_WMASK 16'h3FFF
`define SRT_BLK_WMASK 32'hFFFCB77C
`define SRT_MASK_WMASK 32'hFFFC0000

// ----------------------------------------------------------------------
// dram_control fields
// ----------------------------------------------------------------------
`define SRT_CTRL_SYNC 15
`define SRT_CTRL_NOMUX 13
`define SRT_CTRL_CKECMD 12
`define SRT_CTRL_SELFREQ 11
`define SRT_CTRL_REFRESH_RECOVERY_SEL_HI 10
`define SRT_CTRL_REFRESH_RECOVERY_SEL_LO 9
`define SRT_CTRL_RC_HI 8
`define SRT_CTRL_RC_LO 0

// ----------------------------------------------------------------------
// block address/control and mask fields
// ----------------------------------------------------------------------
`define SRT_BLK_BASE_HI 31
`define SRT_BLK_BASE_LO 18
`define SRT_BLK_UPKEEP 15
`define SRT_BLK_LAT_HI 13
`define SRT_BLK_LAT_LO 12

// ----------------------------------------------------------------------
// timing counts in bus clocks
// ----------------------------------------------------------------------
`define SRT_TRC_00 4'h3
`define SRT_TRC_01 4'h6
`define SRT_TRC_1X 4'h9
`define SRT_T_LAT00 4'h1
`define SRT_T_LAT01 4'h2
`define SRT_T_LAT1X 4'h3
`define SRT_REF_GRAIN 4'hF

// ----------------------------------------------------------------------
// command codes {row, column, write} strobes, active low
// ----------------------------------------------------------------------
`define SRT_CMD_NOP 3'h7
`define SRT_CMD_ACT 3'h3
`define SRT_CMD_RD 3'h5
`define SRT_CMD_WR 3'h4
`define SRT_CMD_PRE 3'h2
`define SRT_CMD_REF 3'h1

`endif

// >>> design/srt_sdram_pkg.sv
package srt_sdram_pkg;

  // ----------------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_RCD = 6'h02,
    S_DATA = 6'h04,
    S_LAST = 6'h08,
    S_SELF = 6'h10,
    S_SPARE = 6'h20
  } srt_state_t;

  // ----------------------------------------------------------------------
  // memory pins
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] csN;
    logic rowStrobeN;
    logic columnStrobeN;
    logic writeEnN;
    logic sdramClockGate;
    logic [12:0] addr;
  } srt_sd_bus_t;

  // ----------------------------------------------------------------------
  // access request from the bus side
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
  } srt_acc_req_t;

endpackage : srt_sdram_pkg

// >>> design/srt_sdram_core.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "srt_sdram_cfg.svh"
// How it works
// - mode 0: gate pin is clock enable
// - mode 1: gate pin carries command, no self-refresh
// - request set enters, cleared exits self-refresh
// - interval counter frozen during self-refresh
// - refresh recovery 3, 6 or 9 clocks
// - one recovery setting for both blocks
// - refresh every (interval+1)*16 clocks
// - hit when unmasked address bits 31:18 match
// - refresh only blocks with upkeep bit set
// - row to column strobe 1,2,3,3 clocks
// - read data 1,2,3,3 clocks after column
// - activate to precharge at least 2,4,6,6
// - precharge to activate 1,2,3,3 clocks
// - one clock from last read data to precharge
// - sync bit sticky until reset
// - column multiplexing unless no_column_mux set
module srt_sdram_core (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // access port
  input srt_sdram_pkg::srt_acc_req_t acc,
  output logic accAck,
  output logic accMiss,
  output logic [1:0] accHit,
  output logic dataStrobe,
  // memory pins
  output srt_sdram_pkg::srt_sd_bus_t sd
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [15:0] dramControl;
  logic [31:0] blockAddrCtrl [2];
  logic [31:0] blockMaskReg [2];
  srt_sdram_pkg::srt_state_t state;
  srt_sdram_pkg::srt_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] gap;
  logic [3:0] age;
  logic [12:0] refCnt;
  logic refPend;
  logic blk;
  logic isWrite;
  logic [31:0] curAddr;

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  wire wrCtrl = regWr && (regAddr == `SRT_OFS_CTRL);
  wire [1:0] wrBlk;
  wire [1:0] wrMask;
  assign wrBlk[0] = regWr && (regAddr == `SRT_OFS_BLK0);
  assign wrBlk[1] = regWr && (regAddr == `SRT_OFS_BLK1);
  assign wrMask[0] = regWr && (regAddr == `SRT_OFS_MASK0);
  assign wrMask[1] = regWr && (regAddr == `SRT_OFS_MASK1);

  // reserved bits are dropped on write and read back as zero
  wire syncMode = dramControl[`SRT_CTRL_SYNC];
  wire [15:0] next_ctrl = (regWdata[15:0] & `SRT_CTRL_WMASK)
                        | {regWdata[15] | syncMode, 15'h0000};
  wire noColumnMux = dramControl[`SRT_CTRL_NOMUX];
  wire ckeCommandMode = dramControl[`SRT_CTRL_CKECMD];
  wire selfRefreshRequest = dramControl[`SRT_CTRL_SELFREQ];
  wire [1:0] refreshRecoverySel =
    dramControl[`SRT_CTRL_REFRESH_RECOVERY_SEL_HI:`SRT_CTRL_REFRESH_RECOVERY_SEL_LO];
  wire [8:0] refreshInterval = dramControl[`SRT_CTRL_RC_HI:`SRT_CTRL_RC_LO];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dramControl <= `SRT_CTRL_RST;
    end else if (wrCtrl) begin
      dramControl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------------
  // per block registers and hit compare
  // ----------------------------------------------------------------------
  wire [1:0] hitRaw;
  wire [1:0] upkeepOn;
  wire [1:0] latSel [2];

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_blk
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          blockAddrCtrl[b] <= `SRT_BLK_RST;
          blockMaskReg[b] <= `SRT_MASK_RST;
        end else begin
          if (wrBlk[b]) begin
            blockAddrCtrl[b] <= regWdata & `SRT_BLK_WMASK;
          end
          if (wrMask[b]) begin
            blockMaskReg[b] <= regWdata & `SRT_MASK_WMASK;
          end
        end
      end
      wire [13:0] baseCmp =
        blockAddrCtrl[b][`SRT_BLK_BASE_HI:`SRT_BLK_BASE_LO];
      wire [13:0] originMask =
        blockMaskReg[b][`SRT_BLK_BASE_HI:`SRT_BLK_BASE_LO];
      // unmasked bits 31:18 must all match
      assign hitRaw[b] = syncMode
        && (((acc.addr[31:18] ^ baseCmp) & ~originMask) == 14'h0000);
      assign upkeepOn[b] = blockAddrCtrl[b][`SRT_BLK_UPKEEP];
      assign latSel[b] =
        blockAddrCtrl[b][`SRT_BLK_LAT_HI:`SRT_BLK_LAT_LO];
    end
  endgenerate

  // block 0 wins when both blocks claim the address
  wire anyHit = |hitRaw;
  wire hitBlk = !hitRaw[0];
  wire anyUpkeep = |upkeepOn;

  // ----------------------------------------------------------------------
  // timing selection
  // ----------------------------------------------------------------------
  wire curBlk = (state == srt_sdram_pkg::S_IDLE) ? hitBlk : blk;
  wire [1:0] readLatencySelect = latSel[curBlk];
  // row-to-column, column-to-data and precharge-to-activate share values
  wire [3:0] tLat = (readLatencySelect == 2'h0) ? `SRT_T_LAT00 :
                    (readLatencySelect == 2'h1) ? `SRT_T_LAT01 :
                    `SRT_T_LAT1X;
  wire [3:0] tRas = {tLat[2:0], 1'b0};
  // one recovery figure serves both blocks
  wire [3:0] tRc = (refreshRecoverySel == 2'h0) ? `SRT_TRC_00 :
                   (refreshRecoverySel == 2'h1) ? `SRT_TRC_01 :
                   `SRT_TRC_1X;
  wire gapOk = (gap <= 4'h1);
  wire [3:0] ageNext = age + 4'h1;
  wire rasOk = (ageNext >= tRas);
  wire [1:0] blkCs = blk ? 2'b01 : 2'b10;

  // ----------------------------------------------------------------------
  // refresh interval counter
  // ----------------------------------------------------------------------
  // reload value gives (refreshInterval + 1) * 16 clocks per period
  wire [12:0] refReload = {refreshInterval, `SRT_REF_GRAIN};
  wire inSelf = (state == srt_sdram_pkg::S_SELF);
  wire selfEnter = syncMode && !ckeCommandMode && selfRefreshRequest;
  logic issueRef;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refCnt <= 13'h0000;
      refPend <= 1'b0;
    end else if (!syncMode) begin
      refCnt <= refReload;
      refPend <= 1'b0;
    end else if (!inSelf) begin
      refCnt <= (refCnt == 13'h0000) ? refReload : refCnt - 13'h0001;
      // expiry wins over the clear of an older pending refresh
      refPend <= (refCnt == 13'h0000) || (refPend && !issueRef);
    end
  end

  // ----------------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------------
  logic [2:0] cmd;
  logic [1:0] next_cs;
  logic next_cke;
  logic next_ack;
  logic next_miss;
  logic next_strobe;
  logic takeReq;
  logic useCol;

  always_comb begin
    next_state = state;
    next_cnt = (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
    cmd = `SRT_CMD_NOP;
    next_cs = 2'b11;
    next_cke = 1'b1;
    next_ack = 1'b0;
    next_miss = 1'b0;
    next_strobe = 1'b0;
    takeReq = 1'b0;
    useCol = 1'b0;
    issueRef = 1'b0;
    case (state)
      srt_sdram_pkg::S_IDLE: begin
        if (selfEnter) begin
          // self-refresh entry to both blocks
          cmd = `SRT_CMD_REF;
          next_cs = 2'b00;
          next_cke = 1'b0;
          next_state = srt_sdram_pkg::S_SELF;
        end else if (refPend && gapOk) begin
          // idle only, so an access never gets cut
          issueRef = 1'b1;
          if (anyUpkeep) begin
            cmd = `SRT_CMD_REF;
            next_cs = ~upkeepOn;
          end
        end else if (acc.req && gapOk && !accAck) begin
          // the master still holds req in the ack cycle: take it once
          next_ack = 1'b1;
          if (anyHit) begin
            cmd = `SRT_CMD_ACT;
            next_cs = hitBlk ? 2'b01 : 2'b10;
            takeReq = 1'b1;
            next_cnt = tLat - 4'h1;
            next_state = srt_sdram_pkg::S_RCD;
          end else begin
            next_miss = 1'b1;
          end
        end
      end
      srt_sdram_pkg::S_RCD: begin
        if (cnt == 4'h0) begin
          cmd = isWrite ? `SRT_CMD_WR : `SRT_CMD_RD;
          next_cs = blkCs;
          useCol = 1'b1;
          next_strobe = isWrite;
          next_cnt = tLat - 4'h1;
          next_state = isWrite ? srt_sdram_pkg::S_LAST
                               : srt_sdram_pkg::S_DATA;
        end
      end
      srt_sdram_pkg::S_DATA: begin
        if (cnt == 4'h0) begin
          next_strobe = 1'b1;
          next_state = srt_sdram_pkg::S_LAST;
        end
      end
      srt_sdram_pkg::S_LAST: begin
        // precharge one clock after last data, tRAS permitting
        if (rasOk) begin
          cmd = `SRT_CMD_PRE;
          next_cs = blkCs;
          next_state = srt_sdram_pkg::S_IDLE;
        end
      end
      srt_sdram_pkg::S_SELF: begin
        next_cke = 1'b0;
        if (!selfRefreshRequest) begin
          next_cke = 1'b1; // exit: clock enable high
          next_state = srt_sdram_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = srt_sdram_pkg::S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer state and spacing counters
  // ----------------------------------------------------------------------
  wire issuePre = (state == srt_sdram_pkg::S_LAST) && rasOk;
  wire [3:0] next_gap = issuePre ? tLat :
                        (issueRef && anyUpkeep) ? tRc :
                        (gap != 4'h0) ? gap - 4'h1 : 4'h0;
  wire [3:0] next_age = takeReq ? 4'h0 :
                        (age != 4'hF) ? ageNext : age;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= srt_sdram_pkg::S_IDLE;
      cnt <= 4'h0;
      gap <= 4'h0;
      age <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      gap <= next_gap;
      age <= next_age;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blk <= 1'b0;
      isWrite <= 1'b0;
      curAddr <= 32'h00000000;
    end else if (takeReq) begin
      blk <= hitBlk;
      isWrite <= acc.write;
      curAddr <= acc.addr;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  wire [12:0] rowAddr = takeReq ? acc.addr[22:10] : curAddr[22:10];
  // column phase multiplexed unless external logic does it
  wire [12:0] colAddr = noColumnMux ? curAddr[22:10]
                                    : {4'h0, curAddr[10:2]};
  wire [12:0] next_addr = useCol ? colAddr :
                          takeReq ? rowAddr : sd.addr;
  // command mode puts the write line level on the gate pin
  wire next_gate = ckeCommandMode ? cmd[0] : next_cke;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sd <= '{csN: 2'b11, rowStrobeN: 1'b1, columnStrobeN: 1'b1,
              writeEnN: 1'b1, sdramClockGate: 1'b1, addr: 13'h0000};
      accAck <= 1'b0;
      accMiss <= 1'b0;
      accHit <= 2'b00;
      dataStrobe <= 1'b0;
    end else begin
      sd <= '{csN: next_cs, rowStrobeN: cmd[2], columnStrobeN: cmd[1],
              writeEnN: cmd[0], sdramClockGate: next_gate,
              addr: next_addr};
      accAck <= next_ack;
      accMiss <= next_miss;
      accHit <= next_ack ? hitRaw : 2'b00;
      dataStrobe <= next_strobe;
    end
  end

  // ----------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------
  wire [31:0] statusWord = {24'h000000, 1'b0, refPend, state};
  wire [31:0] rdMux =
    (regAddr == `SRT_OFS_CTRL) ? {16'h0000, dramControl} :
    (regAddr == `SRT_OFS_STATUS) ? statusWord :
    (regAddr == `SRT_OFS_BLK0) ? blockAddrCtrl[0] :
    (regAddr == `SRT_OFS_BLK1) ? blockAddrCtrl[1] :
    (regAddr == `SRT_OFS_MASK0) ? blockMaskReg[0] :
    (regAddr == `SRT_OFS_MASK1) ? blockMaskReg[1] : 32'h00000000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h00000000;
    end else begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end

endmodule : srt_sdram_core

// >>> verification/srt_sdram_core_properties.sv
`timescale 1ns/100ps
`include "srt_sdram_cfg.svh"
module srt_sdram_core_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // access port
  input wire srt_sdram_pkg::srt_acc_req_t acc,
  input wire logic accAck,
  input wire logic accMiss,
  input wire logic [1:0] accHit,
  input wire logic dataStrobe,
  // memory pins
  input wire srt_sdram_pkg::srt_sd_bus_t sd
);
  // ----------------------------------------------------------------
  // shadow settings and spacing counters
  // ----------------------------------------------------------------
  logic [1:0] refresh_recovery_sel, lat0, lat1, upk, actLat;
  logic ckeCmd;
  logic [4:0] sAct, sCol, sPre, sRef;
  wire [2:0] cmd = {sd.rowStrobeN, sd.columnStrobeN, sd.writeEnN};
  wire isAct = cmd == `SRT_CMD_ACT;
  wire isCol = cmd == `SRT_CMD_RD || cmd == `SRT_CMD_WR;
  wire isRef = cmd == `SRT_CMD_REF;
  wire [4:0] tNow = (actLat == 2'h0) ? 5'h1 : (actLat == 2'h1) ? 5'h2 : 5'h3;
  wire [4:0] tRc = refresh_recovery_sel[1] ? 5'h9 : refresh_recovery_sel[0] ? 5'h6 : 5'h3;
  wire wCtl = regWr && regAddr == `SRT_OFS_CTRL;
  wire wB0 = regWr && regAddr == `SRT_OFS_BLK0;
  wire wB1 = regWr && regAddr == `SRT_OFS_BLK1;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {refresh_recovery_sel, lat0, lat1, upk, actLat, ckeCmd} <= 11'h000;
      {sAct, sCol, sPre, sRef} <= 20'hFFFFF;
    end else begin
      if (wCtl) {ckeCmd, refresh_recovery_sel} <= {regWdata[12], regWdata[10:9]};
      if (wB0) {upk[0], lat0} <= {regWdata[15], regWdata[13:12]};
      if (wB1) {upk[1], lat1} <= {regWdata[15], regWdata[13:12]};
      if (isAct) actLat <= sd.csN[0] ? lat1 : lat0;
      sAct <= isAct ? 5'h1 : sAct + {4'h0, sAct != 5'h1F};
      sCol <= isCol ? 5'h1 : sCol + {4'h0, sCol != 5'h1F};
      sPre <= (cmd == `SRT_CMD_PRE) ? 5'h1 : sPre + {4'h0, sPre != 5'h1F};
      sRef <= isRef ? 5'h1 : sRef + {4'h0, sRef != 5'h1F};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  chk_rcd_gap: assert property (isCol |-> sAct == tNow)
    else $error("row to column spacing wrong");
  chk_read_latency: assert property (dataStrobe && cmd != `SRT_CMD_WR |->
    sCol == tNow) else $error("read data sample late or early");
  chk_write_strobe: assert property (cmd == `SRT_CMD_WR |-> dataStrobe)
    else $error("write data not beside write command");
  chk_ras_min: assert property (cmd == `SRT_CMD_PRE |-> sAct >= (tNow << 1))
    else $error("precharge too soon after activate");
  chk_rp_gap: assert property (isAct |-> sPre >= tNow)
    else $error("activate too soon after precharge");
  chk_pre_after_data: assert property (dataStrobe && cmd != `SRT_CMD_WR |=>
    cmd == `SRT_CMD_PRE) else $error("precharge not after data");
  chk_ref_recovery: assert property (isAct |-> sRef >= tRc)
    else $error("activate inside refresh recovery");
  chk_refresh_blocks: assert property (isRef && sd.sdramClockGate &&
    $stable(upk) |-> sd.csN == ~upk) else $error("refresh block set");
  chk_self_both: assert property (isRef && !sd.sdramClockGate |->
    sd.csN == 2'h0 && !ckeCmd) else $error("self refresh entry wrong");
  chk_gate_command: assert property (ckeCmd && $past(ckeCmd) |->
    sd.sdramClockGate == sd.writeEnN) else $error("gate not command");
  chk_ack_act: assert property (accAck |-> accMiss != isAct)
    else $error("acknowledge and activate disagree");
  chk_ack_pulse: assert property (accAck |=> !accAck)
    else $error("acknowledge longer than one cycle");
  chk_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : srt_sdram_core_properties

bind srt_sdram_core srt_sdram_core_properties u_props (.clk, .resetn,
  .regAddr, .regWdata, .regWr, .regRd, .regRdata, .acc, .accAck,
  .accMiss, .accHit, .dataStrobe, .sd);

// >>> verification/srt_sdram_mem.sv
`timescale 1ns/100ps
`include "srt_sdram_cfg.svh"
module srt_sdram_mem (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // memory pins
  input wire srt_sdram_pkg::srt_sd_bus_t sd,
  // observation
  output logic inSelf,
  output logic [7:0] refCnt0,
  output logic [7:0] refCnt1,
  output logic [7:0] errCnt
);
  wire [2:0] cmd = {sd.rowStrobeN, sd.columnStrobeN, sd.writeEnN};
  wire live = cmd != `SRT_CMD_NOP && sd.csN != 2'h3;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {inSelf, refCnt0, refCnt1, errCnt} <= 25'h0;
    end else if (inSelf) begin
      // asleep: only a raised gate wakes, any command is a fault
      if (sd.sdramClockGate) inSelf <= 1'b0;
      if (live) errCnt <= errCnt + 8'h01;
    end else if (cmd == `SRT_CMD_REF && live) begin
      if (!sd.sdramClockGate) inSelf <= 1'b1;
      if (sd.sdramClockGate && !sd.csN[0]) refCnt0 <= refCnt0 + 8'h01;
      if (sd.sdramClockGate && !sd.csN[1]) refCnt1 <= refCnt1 + 8'h01;
    end
  end
endmodule : srt_sdram_mem

// >>> verification/test_srt_sdram_core.sv
`timescale 1ns/100ps
`include "srt_sdram_cfg.svh"
module test_srt_sdram_core;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  srt_sdram_pkg::srt_acc_req_t acc = '0;
  logic accAck, accMiss, dataStrobe, inSelf;
  logic [1:0] accHit;
  logic [7:0] refCnt0, refCnt1, errCnt;
  srt_sdram_pkg::srt_sd_bus_t sd;
  int fail_count = 0;
  int check_count = 0;
  wire [2:0] cmd = {sd.rowStrobeN, sd.columnStrobeN, sd.writeEnN};
  always #25 clk = ~clk;
  srt_sdram_core dut (.clk, .resetn, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .acc, .accAck, .accMiss, .accHit, .dataStrobe, .sd);
  srt_sdram_mem mem (.clk, .resetn, .sd, .inSelf, .refCnt0, .refCnt1,
    .errCnt);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wrReg
  task automatic rdReg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    check("regRdata", regRdata, exp);
  endtask : rdReg
  task automatic access(input logic [31:0] a, input logic w,
      input logic [1:0] hit, output int d, output logic [12:0] c);
    int i;
    {d, c} = '0;
    @(posedge clk);
    acc <= '{1'b1, w, a};
    for (i = 0; i < 40 && accAck !== 1'b1; i++) @(negedge clk);
    check("accAck", accAck, 1'b1);
    if (accAck !== 1'b1) summarize();
    check("accHit", accHit, hit);
    check("accMiss", accMiss, hit == 2'h0);
    for (int j = 1; j < 16; j++) begin
      @(posedge clk);
      acc.req <= 1'b0;
      @(negedge clk);
      if (cmd == `SRT_CMD_RD || cmd == `SRT_CMD_WR) c = sd.addr;
      if (dataStrobe === 1'b1) d = j;
    end
  endtask : access
  task automatic waitRef(input int lim, output int n);
    for (n = 1; n < lim; n++) begin
      @(negedge clk);
      if (cmd == `SRT_CMD_REF && sd.sdramClockGate === 1'b1) break;
    end
  endtask : waitRef
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdReg(`SRT_OFS_CTRL, 32'h0);
    wrReg(`SRT_OFS_CTRL, 32'h00007FFF);
    rdReg(`SRT_OFS_CTRL, 32'h00003FFF);
    wrReg(`SRT_OFS_CTRL, 32'h00008000);
    wrReg(`SRT_OFS_CTRL, 32'h0);
    rdReg(`SRT_OFS_CTRL, 32'h00008000);
    wrReg(`SRT_OFS_BLK1, 32'hFFFCB7FF);
    rdReg(`SRT_OFS_BLK1, `SRT_BLK_WMASK);
    rdReg(8'h40, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_access();
    int d, t;
    logic [12:0] c;
    wrReg(`SRT_OFS_MASK0, 32'h00040000);
    for (int l = 0; l < 4; l++) begin
      t = (l == 0) ? 1 : (l == 1) ? 2 : 3;
      wrReg(`SRT_OFS_BLK0, {18'h0, l[1:0], 12'h0});
      wrReg(`SRT_OFS_BLK1, {14'h0400, 4'h0, l[1:0], 12'h0});
      wrReg(`SRT_OFS_CTRL, {16'h0, 2'h2, l[0], 4'h0, 9'h1FF});
      access(32'h00040A5C, 1'b0, 2'h1, d, c);
      check("read lat", d, 2 * t);
      check("col", c, l[0] ? 13'h0102 : 13'h0097);
      access(32'h10000004, 1'b1, 2'h2, d, c);
      check("write lat", d, t);
    end
    wrReg(`SRT_OFS_MASK0, 32'h0);
    access(32'h00040A5C, 1'b0, 2'h0, d, c);
    $display("t_access done");
  endtask : t_access
  task automatic t_refresh();
    int n, d;
    logic [12:0] c;
    wrReg(`SRT_OFS_BLK0, 32'h00008000);
    wrReg(`SRT_OFS_BLK1, 32'h10000000);
    for (int r = 0; r < 3; r++) begin
      wrReg(`SRT_OFS_CTRL, {16'h0, 5'h10, r[1:0], 9'h001});
      // the first expiry still runs on the count loaded under the old interval
      waitRef(9000, n);
      check("refresh seen", n < 9000, 1'b1);
      waitRef(100, n);
      check("period", n, 32);
      access(32'h00000010, 1'b0, 2'h1, d, c);
    end
    check("blk1 refs", refCnt1, 8'h00);
    check("blk0 refs", refCnt0 != 8'h00, 1'b1);
    wrReg(`SRT_OFS_BLK0, 32'h0);
    waitRef(100, n);
    check("no refresh", n, 100);
    $display("t_refresh done");
  endtask : t_refresh
  task automatic t_self();
    int n, d;
    logic [12:0] c;
    wrReg(`SRT_OFS_BLK0, 32'h00008000);
    wrReg(`SRT_OFS_CTRL, 32'h0000800F);
    waitRef(600, n);
    // second refresh starts a full period, so the frozen count is large
    waitRef(600, n);
    check("refresh seen", n < 600, 1'b1);
    wrReg(`SRT_OFS_CTRL, 32'h0000880F);
    waitRef(400, n);
    check("asleep", inSelf, 1'b1);
    check("gate low", sd.sdramClockGate, 1'b0);
    check("no auto", n, 400);
    wrReg(`SRT_OFS_CTRL, 32'h0000800F);
    waitRef(600, n);
    check("frozen", n > 200, 1'b1);
    check("awake", inSelf, 1'b0);
    check("gate high", sd.sdramClockGate, 1'b1);
    wrReg(`SRT_OFS_CTRL, 32'h0000980F);
    waitRef(60, n);
    check("no sleep", inSelf, 1'b0);
    access(32'h00000020, 1'b1, 2'h1, d, c);
    wrReg(`SRT_OFS_CTRL, 32'h0000800F);
    check("device faults", errCnt, 8'h00);
    $display("t_self done");
  endtask : t_self
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_access();
    t_refresh();
    t_self();
    summarize();
  end
endmodule : test_srt_sdram_core
